// [logic/odt_decode.sv]
// Functional notes
// - Decode test-against-zero opcodes 3D-7D with cycles.
// - Opcode 9F copies index into accumulator.
// - Opcode 8F clears mask, waits for interrupt.
// - Short indexed: one byte plus index.
// - Long indexed: high, low byte plus index.
// - Full address: high then low byte.
// - Bit branch: direct byte then signed offset.
// - Relative branch: signed byte added to counter.
`default_nettype none
module odt_decode (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    mem_valid,
   input  wire logic [7:0]              mem_data,
   input  wire logic [7:0]              oper_data,
   input  wire logic                    irq_pend,
   input  wire logic                    cond_true,
   output logic                         fetch_req,
   output logic      [15:0]             pc,
   output logic      [15:0]             eff_addr,
   output logic      [7:0]              acc,
   output logic      [7:0]              idx,
   output logic      [4:0]              flag_register,
   output logic      [4:0]              op_group,
   output logic                         clk_halted,
   output logic                         instr_done
);
   import odt_pkg::*;

   odt_state_e  state;
   odt_state_e  next_state;
   logic [7:0]  opcode;
   logic [7:0]  byte1;
   logic [3:0]  cyc_cnt;
   logic [3:0]  cyc_need;

   function automatic logic [1:0] opnd_bytes(input logic [7:0] op);
      logic [3:0] hi;
      hi = op[7:4];
      if (hi <= GRP_BITS_HI) opnd_bytes = (hi == 4'h0) ? 2'd2 : 2'd1;
      else if (hi == GRP_REL) opnd_bytes = 2'd1;
      else if (hi == MODE_EXT || hi == MODE_IX2) opnd_bytes = 2'd2;
      else if (hi == MODE_DIRR || hi == MODE_IXR || hi == MODE_IX1 || hi == MODE_DIRM
               || hi == 4'hA) opnd_bytes = 2'd1;
      else opnd_bytes = 2'd0;
   endfunction

   wire [3:0] op_hi = opcode[7:4];
   wire       is_tst = (opcode[3:0] == LSN_TST) && (op_hi >= MODE_DIRR) && (op_hi <= GRP_RMW_HI);
   wire       is_txa = (opcode == OP_TXA);
   wire       is_wait = (opcode == OP_WAIT);
   wire [1:0] need_bytes = opnd_bytes(opcode);
   // Decoding the operand count from the bus lets an inherent opcode skip the
   // operand state, which would otherwise cost each two-cycle (CYC_INH2) inherent instruction one cycle.
   wire [1:0] fetch_bytes = opnd_bytes(mem_data);
   wire [15:0] sext_m = {{8{mem_data[7]}}, mem_data};
   wire [7:0]  tst_val = (opcode == OP_TST_ACC) ? acc :
                         (opcode == OP_TST_IDX) ? idx : oper_data;
   wire [4:0]  next_group =
      (mem_data[7:4] <= GRP_BITS_HI) ? GRP_BIT :
      (mem_data[7:4] == GRP_REL)     ? GRP_BRA :
      (mem_data[7:4] <= GRP_RMW_HI)  ? GRP_RMW :
      (mem_data[7:4] <= GRP_CTL_HI)  ? GRP_CTL : GRP_REG;

   assign cyc_need = (opcode == OP_TST_DIR) ? CYC_TST_DIR :
                     (opcode == OP_TST_ACC || opcode == OP_TST_IDX) ? CYC_TST_INH :
                     (opcode == OP_TST_IX1) ? CYC_TST_IX1 :
                     (opcode == OP_TST_IX) ? CYC_TST_IX : CYC_INH2;
   // The opcode fetch counts as the first cycle, so execution ends one count early.
   wire       exec_last = (cyc_cnt + CYC_ONE) >= cyc_need;

   always_comb begin
      next_state = state;
      case (state)
         ODT_FETCH: if (mem_valid) next_state = (fetch_bytes == 2'd0) ? ODT_EXEC : ODT_OPND1;
         ODT_OPND1: if (need_bytes == 2'd0) next_state = ODT_EXEC;
                    else if (mem_valid) next_state = (need_bytes == 2'd2) ? ODT_OPND2 : ODT_EXEC;
         ODT_OPND2: if (mem_valid) next_state = ODT_EXEC;
         ODT_EXEC:  if (exec_last) next_state = is_wait ? ODT_WAIT : ODT_FETCH;
         ODT_WAIT:  if (irq_pend) next_state = ODT_FETCH;
         default:   next_state = ODT_FETCH;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ODT_FETCH;
         cyc_cnt <= 4'h0;
      end else begin
         state <= next_state;
         cyc_cnt <= (next_state == ODT_FETCH) ? 4'h0 : cyc_cnt + CYC_ONE;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         opcode <= 8'h00;
         byte1 <= 8'h00;
         pc <= 16'h0000;
         eff_addr <= 16'h0000;
         op_group <= GRP_CTL;
      end else begin
         if ((state == ODT_FETCH || state == ODT_OPND1 || state == ODT_OPND2) && mem_valid
             && !(state == ODT_OPND1 && need_bytes == 2'd0))
            pc <= pc + 16'h0001;
         if (state == ODT_FETCH && mem_valid) begin
            opcode <= mem_data;
            op_group <= next_group;
         end
         if (state == ODT_OPND1 && mem_valid && need_bytes != 2'd0) begin
            byte1 <= mem_data;
            if (op_hi == MODE_IX1 || op_hi == MODE_IXR)
               eff_addr <= {8'h00, mem_data} + {8'h00, idx};
            else if (op_hi == GRP_REL && cond_true)
               pc <= pc + 16'h0001 + sext_m;
            else
               eff_addr <= {8'h00, mem_data};
         end
         if (state == ODT_FETCH && mem_valid && mem_data[7:4] == MODE_IXM)
            eff_addr <= {8'h00, idx};
         if (state == ODT_OPND2 && mem_valid) begin
            if (op_hi == MODE_IX2)
               eff_addr <= {byte1, mem_data} + {8'h00, idx};
            else if (op_hi == MODE_EXT)
               eff_addr <= {byte1, mem_data};
            else if (cond_true)
               pc <= pc + 16'h0001 + sext_m;
            if (op_hi == 4'h0)
               eff_addr <= {8'h00, byte1};
         end
      end
   end

   // The test result reaches the flags at the end of execution, so a waiting
   // memory read has already been returned on oper_data by then.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc <= 8'h00;
         idx <= 8'h00;
         flag_register <= FLG_RESET;
         clk_halted <= 1'b0;
         instr_done <= 1'b0;
      end else begin
         instr_done <= (state == ODT_EXEC) && (next_state != ODT_EXEC);
         clk_halted <= (next_state == ODT_WAIT);
         if (state == ODT_EXEC && next_state != ODT_EXEC) begin
            if (is_tst) begin
               flag_register[FLG_N] <= tst_val[7];
               flag_register[FLG_Z] <= (tst_val == 8'h00);
            end
            if (is_txa) acc <= idx;
            if (is_wait) flag_register[FLG_I] <= 1'b0;
         end
      end
   end

   tst_keep_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_EXEC && is_tst && next_state == ODT_FETCH) |=>
      $stable(acc) && flag_register[FLG_C] == $past(flag_register[FLG_C]))
      else $error("test changed acc or carry");
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) fetch_req <= 1'b0;
      else fetch_req <= (next_state == ODT_FETCH) || (next_state == ODT_OPND1)
                        || (next_state == ODT_OPND2);
   end

   tst_flags_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_EXEC && is_tst && next_state != ODT_EXEC) |=>
      flag_register[FLG_Z] == ($past(tst_val) == 8'h00) && $stable(flag_register[FLG_H])
      && flag_register[FLG_N] == $past(tst_val[7]))
      else $error("test flags wrong");
   txa_copy_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_EXEC && is_txa && next_state != ODT_EXEC) |=>
      acc == $past(idx) && $stable(flag_register))
      else $error("index copy wrong");
   wait_mask_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_WAIT && !irq_pend) |=> !flag_register[FLG_I] && clk_halted)
      else $error("wait mask or halt wrong");
   tst_cycles_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_EXEC && opcode == OP_TST_IX1 && cyc_cnt < CYC_TST_IX1 - CYC_ONE) |=>
      state == ODT_EXEC)
      else $error("test cycle count short");
   ix1_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_OPND1 && mem_valid && op_hi == MODE_IX1) |=>
      eff_addr == {8'h00, $past(mem_data)} + {8'h00, idx})
      else $error("short indexed address wrong");
   ix2_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_OPND2 && mem_valid && op_hi == MODE_IX2) |=>
      eff_addr == {byte1, $past(mem_data)} + {8'h00, idx})
      else $error("long indexed address wrong");
   ext_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_OPND2 && mem_valid && op_hi == MODE_EXT) |=>
      eff_addr == {byte1, $past(mem_data)})
      else $error("full address wrong");
   rel_pc_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_OPND1 && mem_valid && op_hi == GRP_REL && cond_true) |=>
      pc == $past(pc) + 16'h0001 + $past(sext_m))
      else $error("relative target wrong");
   grp_dec_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_FETCH && mem_valid && mem_data[7:4] == GRP_REL) |=> op_group == GRP_BRA)
      else $error("group decode wrong");
   // Named steps of the bit branch: the address byte, then the offset byte.
   sequence bit_addr_s;
      state == ODT_OPND1 && mem_valid && op_hi == 4'h0;
   endsequence
   sequence bit_offset_s;
      state == ODT_OPND2 && mem_valid && op_hi == 4'h0 && cond_true;
   endsequence
   bit_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      bit_addr_s |=> byte1 == $past(mem_data))
      else $error("bit branch address byte wrong");
   bit_pc_a: assert property (@(posedge clk) disable iff (!nrst)
      bit_offset_s |=>
      pc == $past(pc) + 16'h0001 + $past(sext_m) && eff_addr == {8'h00, byte1})
      else $error("bit branch target wrong");
   sequence wait_enter_s;
      state == ODT_EXEC && is_wait;
   endsequence
   wait_entry_a: assert property (@(posedge clk) disable iff (!nrst)
      wait_enter_s |=> state == ODT_WAIT && instr_done)
      else $error("wait entry wrong");
   txa_cycles_a: assert property (@(posedge clk) disable iff (!nrst)
      (state == ODT_EXEC && is_txa) |=> state == ODT_FETCH && instr_done)
      else $error("index copy not one execute cycle");
endmodule // odt_decode
`default_nettype wire

// [logic/odt_pkg.sv]
`default_nettype none
package odt_pkg;
   localparam logic [7:0] OP_TST_DIR  = 8'h3D;
   localparam logic [7:0] OP_TST_ACC  = 8'h4D;
   localparam logic [7:0] OP_TST_IDX  = 8'h5D;
   localparam logic [7:0] OP_TST_IX1  = 8'h6D;
   localparam logic [7:0] OP_TST_IX   = 8'h7D;
   localparam logic [7:0] OP_TXA      = 8'h9F;
   localparam logic [7:0] OP_WAIT     = 8'h8F;
   localparam logic [3:0] LSN_TST     = 4'hD;
   localparam logic [3:0] GRP_BITS_HI = 4'h1;
   localparam logic [3:0] GRP_REL     = 4'h2;
   localparam logic [3:0] GRP_RMW_HI  = 4'h7;
   localparam logic [3:0] GRP_CTL_HI  = 4'h9;
   localparam logic [3:0] MODE_EXT    = 4'hC;
   localparam logic [3:0] MODE_IX2    = 4'hD;
   localparam logic [3:0] MODE_IX1    = 4'hE;
   localparam logic [3:0] MODE_IXR    = 4'h6;
   localparam logic [3:0] MODE_IXM    = 4'h7;
   localparam logic [3:0] MODE_DIRR   = 4'h3;
   localparam logic [3:0] MODE_DIRM   = 4'hB;
   localparam logic [3:0] CYC_TST_DIR = 4'h4;
   localparam logic [3:0] CYC_TST_INH = 4'h3;
   localparam logic [3:0] CYC_TST_IX1 = 4'h5;
   localparam logic [3:0] CYC_TST_IX  = 4'h4;
   localparam logic [3:0] CYC_INH2    = 4'h2;
   localparam logic [3:0] CYC_ONE     = 4'h1;
   // Flag register bit positions: H I N Z C.
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_I = 3;
   localparam int FLG_H = 4;
   localparam logic [4:0] FLG_RESET = 5'h08;
   typedef enum logic [4:0] {
      ODT_FETCH = 5'b0_0001,
      ODT_OPND1 = 5'b0_0010,
      ODT_OPND2 = 5'b0_0100,
      ODT_EXEC  = 5'b0_1000,
      ODT_WAIT  = 5'b1_0000
   } odt_state_e;
   typedef enum logic [4:0] {
      GRP_BIT = 5'b0_0001,
      GRP_BRA = 5'b0_0010,
      GRP_RMW = 5'b0_0100,
      GRP_CTL = 5'b0_1000,
      GRP_REG = 5'b1_0000
   } odt_group_e;
endpackage
`default_nettype wire

// [test/odt_prog_mem.sv]
`default_nettype none
module odt_prog_mem (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        slow,
   input  wire logic        fetch_req,
   input  wire logic [15:0] pc,
   output logic             mem_valid,
   output logic      [7:0]  mem_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic       gap;
   logic [7:0] last;
   // Slow mode offers a byte only every other cycle, so the decoder must honour valid.
   assign mem_valid = fetch_req && !(slow && gap);
   // Bytes come in program order, high byte first for two-byte fields.
   assign mem_data  = mem_valid ? mem[pc[7:0]] : ~last;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap  <= 1'b0;
         last <= 8'h00;
      end else begin
         gap <= !gap;
         if (mem_valid) begin
            last <= mem_data;
         end
      end
   end
endmodule // odt_prog_mem
`default_nettype wire

// [test/odt_decode_tb.sv]
`default_nettype none
module odt_decode_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import odt_pkg::*;
   localparam logic [7:0] PROG [19] = '{8'h3D, 8'h40, 8'h4D, 8'h5D, 8'h6D, 8'h21, 8'h7D,
      8'h9F, 8'h8F, 8'hC6, 8'h56, 8'h78, 8'hD6, 8'h12, 8'h34, 8'hE6, 8'h9A, 8'h20, 8'h10};
   logic        clk, nrst, slow, irq_pend, cond_true, mem_valid, fetch_req;
   logic        clk_halted, instr_done;
   logic [7:0]  mem_data, oper_data, acc, idx;
   logic [4:0]  flags, op_group;
   logic [15:0] pc, eff_addr;
   int          errors, total_checks, cycles, n;
   odt_decode dut_u (.clk(clk), .nrst(nrst), .mem_valid(mem_valid), .mem_data(mem_data),
      .oper_data(oper_data), .irq_pend(irq_pend), .cond_true(cond_true),
      .fetch_req(fetch_req), .pc(pc), .eff_addr(eff_addr), .acc(acc), .idx(idx),
      .flag_register(flags), .op_group(op_group), .clk_halted(clk_halted),
      .instr_done(instr_done));
   odt_prog_mem mem_u (.clk(clk), .nrst(nrst), .slow(slow), .fetch_req(fetch_req),
      .pc(pc), .mem_valid(mem_valid), .mem_data(mem_data));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Flags are checked at the next opcode fetch, once the previous result has landed.
   task automatic run(input string what, input logic [15:0] at, input logic [5:0] fl,
                      input int cyc, input logic [4:0] grp);
      n = 0;
      while (mem_valid !== 1'b1) @(negedge clk);
      check({what, " pc"}, pc, at);
      if (!fl[5]) check({what, " flags"}, 16'(flags), 16'(fl[4:0]));
      if (!fl[5]) check({what, " acc"}, 16'(acc), 16'h0000);
      do begin
         @(negedge clk);
         n++;
      end while (instr_done !== 1'b1 && n < 40);
      if (cyc > 0) check({what, " cycles"}, 16'(n), 16'(cyc));
      check({what, " group"}, 16'(op_group), 16'(grp));
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      {nrst, slow, irq_pend, errors, total_checks, cycles} = '0;
      cond_true = 1'b1;
      oper_data = 8'h80;
      for (int i = 0; i < 256; i++) mem_u.mem[i] = 8'h9F;
      for (int i = 0; i < 19; i++) mem_u.mem[i] = PROG[i];
      {mem_u.mem[35], mem_u.mem[36], mem_u.mem[37]} = {8'h05, 8'h44, 8'hF0};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check("reset group", 16'(op_group), 16'h0008);
      run("tst dir", 16'h0000, 6'h08, 4, 5'h04);
      run("tst acc", 16'h0002, 6'h0C, 3, 5'h04);
      run("tst idx", 16'h0003, 6'h0A, 3, 5'h04);
      run("tst ix1", 16'h0004, 6'h0A, 5, 5'h04);
      check("ix1 addr", eff_addr, 16'h0021);
      run("tst ix", 16'h0006, 6'h0C, 4, 5'h04);
      check("ix addr", eff_addr, 16'h0000);
      run("txa", 16'h0007, 6'h0C, 2, 5'h08);
      run("wait", 16'h0008, 6'h0C, 2, 5'h08);
      repeat (5) @(negedge clk);
      check("halted", 16'(clk_halted), 16'h0001);
      check("wait flags", 16'(flags), 16'h0004);
      @(posedge clk);
      irq_pend <= 1'b1;
      slow     <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (clk_halted === 1'b1 && n < 10);
      check("woken", 16'(clk_halted), 16'h0000);
      @(posedge clk);
      irq_pend <= 1'b0;
      @(negedge clk);
      run("ext", 16'h0009, 6'h04, 0, 5'h10);
      check("ext addr", eff_addr, 16'h5678);
      run("ix2", 16'h000C, 6'h20, 0, 5'h10);
      check("ix2 addr", eff_addr, 16'h1234);
      run("ix1", 16'h000F, 6'h20, 0, 5'h10);
      check("ix1 addr", eff_addr, 16'h009A);
      run("rel", 16'h0011, 6'h20, 0, 5'h02);
      run("bit branch", 16'h0023, 6'h20, 0, 5'h01);
      check("bit addr", eff_addr, 16'h0044);
      run("after", 16'h0016, 6'h20, 2, 5'h08);
      report_and_stop();
   end
endmodule // odt_decode_tb
`default_nettype wire
